// file: verilog/adccr_map.svh
// Register offsets, field positions and reset values of the channel
// calibration and configuration bank.
// Assumes inclusion by both design files.
`ifndef ADCCR_MAP_SVH
`define ADCCR_MAP_SVH

`define ADCCR_ADDR_W          6
`define ADCCR_OFS_CH5_GAIN_LO 6'h26
`define ADCCR_OFS_CHANNEL6_CONFIG     6'h27
`define ADCCR_OFS_CH6_OFS_HI  6'h28
`define ADCCR_OFS_CH6_OFS_LO  6'h29
`define ADCCR_OFS_CH6_GAIN_HI 6'h2A
`define ADCCR_OFS_CH6_GAIN_LO 6'h2B
`define ADCCR_OFS_CHANNEL7_CONFIG     6'h2C

`define ADCCR_CFG_PHASE_MSB   15
`define ADCCR_CFG_PHASE_LSB   6
`define ADCCR_CFG_DCOFF_BIT   2
`define ADCCR_CFG_MUX_MSB     1
`define ADCCR_CFG_MUX_LSB     0
`define ADCCR_LO_FIELD_MSB    15
`define ADCCR_LO_FIELD_LSB    8

`define ADCCR_RST_CFG         16'h0000
`define ADCCR_RST_OFS_HI      16'h0000
`define ADCCR_RST_LO_BYTE     8'h00
`define ADCCR_RST_GAIN_HI     16'h8000
`define ADCCR_RD_ZERO         16'h0000

`endif

// file: verilog/adccr_pkg.sv
// Types shared by the channel calibration and configuration bank.
// Assumes adccr_map.svh is available on the include path.
`default_nettype none
package adccr_pkg;
  typedef enum logic [1:0] {
    ADCCR_IN_OWN_PAIR,
    ADCCR_IN_SHORTED,
    ADCCR_IN_TEST_POS,
    ADCCR_IN_TEST_NEG
  } adccr_input_e;

  typedef struct packed {
    logic signed [9:0] phase_delay;
    logic              dc_filter_off;
    adccr_input_e      input_select;
  } adccr_chan_cfg_s;

  typedef struct packed {
    logic signed [23:0] offset;
    logic        [23:0] gain;
  } adccr_chan_cal_s;

  typedef logic [15:0] adccr_word_t;
endpackage
`default_nettype wire

// file: verilog/adccr_word_reg.sv
// One 16-bit register word with a per-bit writable mask and reset value.
// Assumes a synchronous write strobe on clk_sys.
`include "adccr_map.svh"
`default_nettype none
module adccr_word_reg #(
  parameter logic [15:0] RST_VAL  = 16'h0000,
  parameter logic [15:0] WR_MASK  = 16'hFFFF
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 wr_en,
  input  wire adccr_pkg::adccr_word_t wr_data,
  output var  adccr_pkg::adccr_word_t value
);
  import adccr_pkg::*;

  adccr_word_t next_value;

  // Read-only bits held at zero
  assign next_value = wr_en ? (wr_data & WR_MASK) : value;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      value <= RST_VAL;
    end else begin
      value <= next_value;
    end
  end
endmodule
`default_nettype wire

// file: verilog/adccr_regs.sv
// Channel configuration and calibration register bank, channels 5 to 7.
// Assumes a single-cycle strobe master on clk_sys, no wait states.
//
// Summary of operation
// RULE_01 - Bits 15:6 hold signed phase delay
// RULE_02 - Bit 2 set disables channel DC filter
// RULE_03 - Selector 01 short, 10 test+, 11 test-
// RULE_04 - Selector resets to 00, own inputs
// RULE_05 - Config bits 5:3 read as zero
// RULE_06 - Offset high holds offset bits 23:8
// RULE_07 - Offset low upper byte holds bits 7:0
// RULE_08 - Gain high holds gain bits 23:8
// RULE_09 - Gain low upper byte holds bits 7:0
// RULE_10 - Gain code is unsigned multiplier
// RULE_11 - Gain high resets to 8000h, unity
// RULE_12 - Low registers lower byte reads zero
// RULE_13 - Config register resets to zero
// RULE_14 - Writes to read-only bits are ignored
`include "adccr_map.svh"
`default_nettype none
module adccr_regs (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic [5:0]                 reg_addr,
  input  wire adccr_pkg::adccr_word_t     reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output var  adccr_pkg::adccr_word_t     reg_rdata,
  output var  adccr_pkg::adccr_chan_cfg_s ch_six_cfg,
  output var  adccr_pkg::adccr_chan_cfg_s ch_seven_cfg,
  output var  adccr_pkg::adccr_chan_cal_s ch_six_cal,
  output var  logic [7:0]                 ch_five_gain_low,
  output var  logic                       ch_six_dc_filter_on,
  output var  logic                       ch_seven_dc_filter_on,
  input  wire logic                       global_dc_filter_setting
);
  import adccr_pkg::*;

  localparam int NREG = 7;
  localparam logic [6*NREG-1:0] OFS = {
    `ADCCR_OFS_CHANNEL7_CONFIG, `ADCCR_OFS_CH6_GAIN_LO, `ADCCR_OFS_CH6_GAIN_HI,
    `ADCCR_OFS_CH6_OFS_LO, `ADCCR_OFS_CH6_OFS_HI, `ADCCR_OFS_CHANNEL6_CONFIG,
    `ADCCR_OFS_CH5_GAIN_LO};
  // RULE_05 RULE_14 config writable mask
  localparam logic [15:0] CFG_MASK = 16'hFFC7;
  // RULE_12 RULE_14 low-byte read-only mask
  localparam logic [15:0] LO_MASK  = 16'hFF00;
  localparam logic [15:0] HI_MASK  = 16'hFFFF;
  localparam logic [16*NREG-1:0] MASKS = {
    CFG_MASK, LO_MASK, HI_MASK, LO_MASK, HI_MASK, CFG_MASK, LO_MASK};
  // RULE_04 RULE_11 RULE_13 reset values
  localparam logic [16*NREG-1:0] RSTS = {
    `ADCCR_RST_CFG, {`ADCCR_RST_LO_BYTE, 8'h00}, `ADCCR_RST_GAIN_HI,
    {`ADCCR_RST_LO_BYTE, 8'h00}, `ADCCR_RST_OFS_HI, `ADCCR_RST_CFG,
    {`ADCCR_RST_LO_BYTE, 8'h00}};

  adccr_word_t          word   [NREG];
  logic [NREG-1:0]      hit;
  adccr_word_t          next_reg_rdata;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gen_reg
      assign hit[g] = (reg_addr == OFS[6*g +: 6]);
      adccr_word_reg #(
        .RST_VAL (RSTS[16*g +: 16]),
        .WR_MASK (MASKS[16*g +: 16])
      ) u_word (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .wr_en   (reg_wr & hit[g]),
        .wr_data (reg_wdata),
        .value   (word[g])
      );
    end
  endgenerate

  // Unmapped reads return zero
  always_comb begin
    next_reg_rdata = `ADCCR_RD_ZERO;
    for (int i = 0; i < NREG; i++) begin
      if (reg_rd && hit[i]) begin
        next_reg_rdata = word[i];
      end
    end
  end

  adccr_chan_cfg_s next_six_cfg;
  adccr_chan_cfg_s next_seven_cfg;
  adccr_chan_cal_s next_six_cal;

  // RULE_01 phase delay field
  assign next_six_cfg.phase_delay =
    word[1][`ADCCR_CFG_PHASE_MSB:`ADCCR_CFG_PHASE_LSB];
  assign next_seven_cfg.phase_delay =
    word[6][`ADCCR_CFG_PHASE_MSB:`ADCCR_CFG_PHASE_LSB];
  // RULE_02 channel filter disable
  assign next_six_cfg.dc_filter_off   = word[1][`ADCCR_CFG_DCOFF_BIT];
  assign next_seven_cfg.dc_filter_off = word[6][`ADCCR_CFG_DCOFF_BIT];
  // RULE_03 input selector decode
  assign next_six_cfg.input_select =
    adccr_input_e'(word[1][`ADCCR_CFG_MUX_MSB:`ADCCR_CFG_MUX_LSB]);
  assign next_seven_cfg.input_select =
    adccr_input_e'(word[6][`ADCCR_CFG_MUX_MSB:`ADCCR_CFG_MUX_LSB]);
  // RULE_06 RULE_07 offset assembly
  assign next_six_cal.offset = {word[2],
    word[3][`ADCCR_LO_FIELD_MSB:`ADCCR_LO_FIELD_LSB]};
  // RULE_08 RULE_09 RULE_10 unsigned gain assembly
  assign next_six_cal.gain = {word[4],
    word[5][`ADCCR_LO_FIELD_MSB:`ADCCR_LO_FIELD_LSB]};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata             <= `ADCCR_RD_ZERO;
      ch_six_cfg            <= '0;
      ch_seven_cfg          <= '0;
      ch_six_cal            <= {24'h000000, 24'h800000};
      ch_five_gain_low      <= 8'h00;
      ch_six_dc_filter_on   <= 1'b0;
      ch_seven_dc_filter_on <= 1'b0;
    end else begin
      reg_rdata             <= next_reg_rdata;
      ch_six_cfg            <= next_six_cfg;
      ch_seven_cfg          <= next_seven_cfg;
      ch_six_cal            <= next_six_cal;
      ch_five_gain_low      <=
        word[0][`ADCCR_LO_FIELD_MSB:`ADCCR_LO_FIELD_LSB];
      // RULE_02 filter on needs global setting and no local disable
      ch_six_dc_filter_on   <= global_dc_filter_setting &
                               !next_six_cfg.dc_filter_off;
      ch_seven_dc_filter_on <= global_dc_filter_setting &
                               !next_seven_cfg.dc_filter_off;
    end
  end
endmodule
`default_nettype wire

// file: sim/adccr_regs_chk.sv
// Port assertions for the channel register bank.
// Assumes the one-cycle strobe bus and registered outputs.
`default_nettype none
module adccr_regs_chk import adccr_pkg::*; (
  input wire logic            clk_sys,
  input wire logic            nrst,
  input wire logic [5:0]      reg_addr,
  input wire adccr_word_t     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire adccr_word_t     reg_rdata,
  input wire adccr_chan_cfg_s ch_six_cfg,
  input wire adccr_chan_cfg_s ch_seven_cfg,
  input wire adccr_chan_cal_s ch_six_cal,
  input wire logic            ch_six_dc_filter_on,
  input wire logic            ch_seven_dc_filter_on,
  input wire logic            global_dc_filter_setting
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_cfg_rsv; reg_rd && reg_addr inside {6'h27, 6'h2C} |=>
    reg_rdata[5:3] == 3'h0; endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("cfg rsv");
  property p_lo_rsv; reg_rd && reg_addr inside {6'h26, 6'h29, 6'h2B} |=>
    reg_rdata[7:0] == 8'h00; endproperty
  a_lo_rsv: assert property (p_lo_rsv) else $error("low rsv");
  property p_unmap; reg_rd && reg_addr > 6'h2C |=> reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_cfg6; reg_wr && reg_addr == 6'h27 |-> ##2 ch_six_cfg ==
    {$past(reg_wdata[15:6], 2), $past(reg_wdata[2:0], 2)}; endproperty
  a_cfg6: assert property (p_cfg6) else $error("cfg6");
  property p_cfg7; reg_wr && reg_addr == 6'h2C |-> ##2 ch_seven_cfg ==
    {$past(reg_wdata[15:6], 2), $past(reg_wdata[2:0], 2)}; endproperty
  a_cfg7: assert property (p_cfg7) else $error("cfg7");
  property p_ofs_hi; reg_wr && reg_addr == 6'h28 |-> ##2
    ch_six_cal.offset[23:8] == $past(reg_wdata, 2); endproperty
  a_ofs_hi: assert property (p_ofs_hi) else $error("ofs hi");
  property p_gain_lo; reg_wr && reg_addr == 6'h2B |-> ##2
    ch_six_cal.gain[7:0] == $past(reg_wdata[15:8], 2); endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain lo");
  property p_dc6; $past(nrst) && !$past(global_dc_filter_setting) |->
    !ch_six_dc_filter_on; endproperty
  a_dc6: assert property (p_dc6) else $error("dc6");
  property p_dc7; ch_seven_cfg.dc_filter_off &&
    $past(ch_seven_cfg.dc_filter_off) |-> !ch_seven_dc_filter_on; endproperty
  a_dc7: assert property (p_dc7) else $error("dc7");
endmodule
bind adccr_regs adccr_regs_chk chk_u (.*);
`default_nettype wire

// file: sim/test_adccr_regs.sv
// Self-checking bench for the channel register bank.
// Assumes the one-cycle strobe bus and a 100 MHz clock.
`default_nettype none
module test_adccr_regs import adccr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk_sys = 1'b0;
  logic            nrst = 1'b0;
  logic [5:0]      reg_addr = 6'h00;
  adccr_word_t     reg_wdata = 16'h0000;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            global_dc_filter_setting = 1'b0;
  adccr_word_t     reg_rdata;
  adccr_chan_cfg_s ch_six_cfg;
  adccr_chan_cfg_s ch_seven_cfg;
  adccr_chan_cal_s ch_six_cal;
  logic [7:0]      ch_five_gain_low;
  logic            ch_six_dc_filter_on;
  logic            ch_seven_dc_filter_on;
  int              mismatches = 0;
  int              n_tests = 0;
  adccr_regs dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch_six_cfg(ch_six_cfg),
    .ch_seven_cfg(ch_seven_cfg), .ch_six_cal(ch_six_cal),
    .ch_five_gain_low(ch_five_gain_low),
    .ch_six_dc_filter_on(ch_six_dc_filter_on),
    .ch_seven_dc_filter_on(ch_seven_dc_filter_on),
    .global_dc_filter_setting(global_dc_filter_setting));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [5:0] a, input adccr_word_t d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input adccr_word_t e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task t_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    chk("cal", 48'h000000800000, ch_six_cal);
    for (int i = 0; i < 7; i++)
      rd(6'(6'h26 + i), (i == 4) ? 16'h8000 : 16'h0000);
    $display("t_reset done");
  endtask
  task t_rw;
    for (int i = 0; i < 7; i++) wr(6'(6'h26 + i), 16'hFFFF);
    for (int i = 0; i < 7; i++) rd(6'(6'h26 + i), (i == 1 || i == 6) ?
      16'hFFC7 : (i == 2 || i == 4) ? 16'hFFFF : 16'hFF00);
    chk("cal", 48'hFFFFFFFFFFFF, ch_six_cal);
    chk("ch5", 48'hFF, ch_five_gain_low);
    $display("t_rw done");
  endtask
  task t_mux;
    for (int m = 0; m < 4; m++) begin
      wr(6'h2C, 16'h8038 | 16'(m));
      @(posedge clk_sys);
      #1 chk("cfg7", {10'h200, 1'b0, 2'(m)}, ch_seven_cfg);
    end
    $display("t_mux done");
  endtask
  task t_dc;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      global_dc_filter_setting <= k[1];
      wr(6'h27, k[0] ? 16'h0004 : 16'h0000);
      repeat (3) @(posedge clk_sys);
      #1 chk("dc6", k[1] & ~k[0], ch_six_dc_filter_on);
      chk("dc7", k[1], ch_seven_dc_filter_on);
    end
    $display("t_dc done");
  endtask
  task t_unmap;
    wr(6'h30, 16'hFFFF);
    rd(6'h30, 16'h0000);
    rd(6'h3F, 16'h0000);
    $display("t_unmap done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_reset;
    t_rw;
    t_mux;
    t_dc;
    t_unmap;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
